/* File: agc_loop_filter_model.sv */
// Purpose: Loop filter stand-in answering an error with a gain; an error during the wait restarts it
// Assumes: Gain word zero means unity
// Notes:   Gain lines carry junk outside the valid pulse
module agc_loop_filter_model (
  // Clock and reset
  input  wire logic        ref_clk_i,
  input  wire logic        arst_n_i,
  // Error in, gain out
  input  wire logic        err_valid_i,
  input  wire logic [3:0]  delay_i,
  output logic             gain_valid_o,
  output logic      [11:0] gain_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] wait_q;
  logic       busy_q;
  logic       fire;
  assign fire = busy_q && (wait_q == 4'h0);
  // One answer after a fast or slow wait; a newer update restarts the wait, leaving one answer for both
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      busy_q       <= 1'b0;
      wait_q       <= 4'h0;
      gain_valid_o <= 1'b0;
      gain_o       <= 12'hFFF;
    end else begin
      gain_valid_o <= fire;
      gain_o       <= fire ? 12'h000 : ~gain_o;
      if (err_valid_i) begin
        busy_q <= 1'b1;
        wait_q <= delay_i;
      end else if (wait_q != 4'h0) begin
        wait_q <= wait_q - 4'h1;
      end else begin
        busy_q <= 1'b0;
      end
    end
  end
endmodule : agc_loop_filter_model

/* File: agc_map.svh */
// Purpose: Offsets, field positions, reset values, sizes and limits
// Assumes: Included by the gain error path design and checker files
// Notes:   Word-indexed register port, 32-bit data, low bits used
`ifndef AGC_MAP_SVH
`define AGC_MAP_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define AGC_OFS_CTRL       4'h0
`define AGC_OFS_TARGET     4'h1
`define AGC_OFS_RATIO      4'h2
`define AGC_OFS_AVG        4'h3
`define AGC_OFS_CLIPLVL    4'h4
`define AGC_OFS_GAIN       4'h5
`define AGC_OFS_ERROR      4'h6
`define AGC_OFS_STATUS     4'h7

// ----------------------------------------------------------------
// Control field positions
// ----------------------------------------------------------------
`define AGC_CTRL_BYPASS    0
`define AGC_CTRL_CLIPMODE  1
`define AGC_CTRL_WL_LO     2
`define AGC_CTRL_WL_HI     4

// Average register: multiplier code in [1:0], scale in [7:4]
`define AGC_AVG_MUL_LO     0
`define AGC_AVG_MUL_HI     1
`define AGC_AVG_SCL_LO     4
`define AGC_AVG_SCL_HI     7

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define AGC_RST_CTRL       8'h00
`define AGC_RST_TARGET     8'h00
`define AGC_RST_RATIO      12'h000
`define AGC_RST_AVG        8'h00
`define AGC_RST_CLIPLVL    8'h00
`define AGC_RST_GAIN       12'h000

// ----------------------------------------------------------------
// Sizes and limits
// ----------------------------------------------------------------
`define AGC_IN_W           24
`define AGC_OUT_W          16
`define AGC_SCALE_MAX      4'hE
`define AGC_PWR_W          48
`define AGC_ACC_W          64
`define AGC_LOG_W          12

`endif

/* File: agc_pkg.sv */
// Purpose: Types for the gain error path
// Assumes: Constants live in agc_map.svh
// Notes:   Word length codes select 4..16 bit outputs
package agc_pkg;

  typedef enum logic [2:0] {
    AGC_WL_4  = 3'h0,
    AGC_WL_5  = 3'h1,
    AGC_WL_6  = 3'h2,
    AGC_WL_7  = 3'h3,
    AGC_WL_8  = 3'h4,
    AGC_WL_10 = 3'h5,
    AGC_WL_12 = 3'h6,
    AGC_WL_16 = 3'h7
  } agc_wlen_t;

  typedef enum logic [2:0] {
    AGC_ST_IDLE = 3'b001,
    AGC_ST_LOG  = 3'b010,
    AGC_ST_ERR  = 3'b100
  } agc_state_t;

endpackage : agc_pkg

/* File: agc_power_error_path.sv */
// Purpose: One gain control channel: power, average, log, error, gain
// Assumes: Samples arrive with a valid strobe on ref_clk_i
// Notes:   Loop filter is outside; gain comes back on loop_gain_i
//
// Notes on behaviour
// - Six independent loops, 96 dB gain range each; this module implements one loop
// - Output width selectable 4..16 bits per component
// - Three-bit word length field selects width
// - Bypass skips loop, truncates input to 16
// - Power, error, filter, gain stages in sequence
// - Mode bit zero selects signal level tracking
// - Signal mode measures pre-clip samples only
// - Clip mode measures pre minus post clip
// - Power is I squared plus Q squared
// - Averaging on power, window up to 16384
// - Gain updated once every M samples
// - Window is ratio times multiplier one..four
// - One first-order integrate-comb decimator
// - Power right shifted 0..14 before decimator
// - Log2 of decimated power, halve for rms
// - Error is request level minus log rms
// - Request spans 0 to -23.99 dB
// - Level word: 2-bit exponent, 6-bit mantissa
// - Mode bit one uses clipping level instead
// - Gain applied as 4-bit shift, 8-bit multiply
//
// Implementation choices: the address-and-strobe port and the placing of the registers.
`include "agc_map.svh"

module agc_power_error_path (
  // Clock and reset
  input  wire logic                   ref_clk_i,
  input  wire logic                   arst_n_i,
  // Register port
  input  wire logic [3:0]             reg_addr_i,
  input  wire logic [31:0]            reg_wdata_i,
  input  wire logic                   reg_wr_i,
  input  wire logic                   reg_rd_i,
  output logic      [31:0]            reg_rdata_o,
  // Sample input
  input  wire logic                   in_valid_i,
  input  wire logic [23:0]            in_i_i,
  input  wire logic [23:0]            in_q_i,
  // Loop filter hand-off
  output logic                        err_valid_o,
  output logic      [11:0]            err_o,
  input  wire logic                   loop_gain_valid_i,
  input  wire logic [11:0]            loop_gain_i,
  // Sample output
  output logic                        out_valid_o,
  output logic      [15:0]            out_i_o,
  output logic      [15:0]            out_q_o
);
  import agc_pkg::*;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [7:0]  ctrl_q;
  logic [7:0]  target_output_level_q;
  logic [11:0] ratio_q;
  logic [7:0]  avg_q;
  logic [7:0]  clip_level_q;
  logic [11:0] gain_q;
  logic [11:0] err_q;
  agc_state_t  state_q;
  logic        bypass;
  logic        clip_mode;
  agc_wlen_t   wlen;
  logic [1:0]  mul_code;
  logic [3:0]  scale;

  assign bypass    = ctrl_q[`AGC_CTRL_BYPASS];
  assign clip_mode = ctrl_q[`AGC_CTRL_CLIPMODE];
  assign wlen      = agc_wlen_t'(ctrl_q[`AGC_CTRL_WL_HI:`AGC_CTRL_WL_LO]);
  assign mul_code  = avg_q[`AGC_AVG_MUL_HI:`AGC_AVG_MUL_LO];
  assign scale     = avg_q[`AGC_AVG_SCL_HI:`AGC_AVG_SCL_LO];

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ctrl_q                <= `AGC_RST_CTRL;
      target_output_level_q <= `AGC_RST_TARGET;
      ratio_q               <= `AGC_RST_RATIO;
      avg_q                 <= `AGC_RST_AVG;
      clip_level_q          <= `AGC_RST_CLIPLVL;
    end else if (reg_wr_i) begin
      case (reg_addr_i)
        `AGC_OFS_CTRL:    ctrl_q                <= reg_wdata_i[7:0];
        `AGC_OFS_TARGET:  target_output_level_q <= reg_wdata_i[7:0];
        `AGC_OFS_RATIO:   ratio_q               <= reg_wdata_i[11:0];
        `AGC_OFS_AVG:     avg_q                 <= reg_wdata_i[7:0];
        `AGC_OFS_CLIPLVL: clip_level_q          <= reg_wdata_i[7:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Read port: data one cycle after the strobe, zero otherwise
  // ----------------------------------------------------------------
  logic [31:0] rdata_d;
  always_comb begin
    rdata_d = 32'h0;
    case (reg_addr_i)
      `AGC_OFS_CTRL:    rdata_d = {24'h0, ctrl_q};
      `AGC_OFS_TARGET:  rdata_d = {24'h0, target_output_level_q};
      `AGC_OFS_RATIO:   rdata_d = {20'h0, ratio_q};
      `AGC_OFS_AVG:     rdata_d = {24'h0, avg_q};
      `AGC_OFS_CLIPLVL: rdata_d = {24'h0, clip_level_q};
      `AGC_OFS_GAIN:    rdata_d = {20'h0, gain_q};
      `AGC_OFS_ERROR:   rdata_d = {20'h0, err_q};
      `AGC_OFS_STATUS:  rdata_d = {29'h0, state_q};
      default:          rdata_d = 32'h0;
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      reg_rdata_o <= 32'h0;
    end else begin
      reg_rdata_o <= reg_rd_i ? rdata_d : 32'h0;
    end
  end

  // ----------------------------------------------------------------
  // Gain multiplication: coarse shift then fine multiply
  // ----------------------------------------------------------------
  // Gain word: exponent [11:8] shifts left, mantissa [7:0] scales
  // by (256 + m)/256, so the 96 dB range is 16 x 6.02 dB.
  logic signed [47:0] sh_i, sh_q, mul_i, mul_q;
  logic signed [23:0] g_i, g_q;
  always_comb begin
    sh_i  = 48'(signed'(in_i_i)) <<< gain_q[11:8];
    sh_q  = 48'(signed'(in_q_i)) <<< gain_q[11:8];
    mul_i = 48'((sh_i * signed'({1'b0, 9'h100 + 9'(gain_q[7:0])})) >>> 8);
    mul_q = 48'((sh_q * signed'({1'b0, 9'h100 + 9'(gain_q[7:0])})) >>> 8);
    // Saturate to 24 bits; wider growth would wrap the sign
    g_i = (mul_i > 48'sh7FFFFF)  ? 24'h7FFFFF :
          (mul_i < -48'sh800000) ? 24'h800000 : mul_i[23:0];
    g_q = (mul_q > 48'sh7FFFFF)  ? 24'h7FFFFF :
          (mul_q < -48'sh800000) ? 24'h800000 : mul_q[23:0];
  end

  // ----------------------------------------------------------------
  // Clipping to the selected word length
  // ----------------------------------------------------------------
  logic [4:0] keep;
  always_comb begin
    case (wlen)
      AGC_WL_4:  keep = 5'd4;
      AGC_WL_5:  keep = 5'd5;
      AGC_WL_6:  keep = 5'd6;
      AGC_WL_7:  keep = 5'd7;
      AGC_WL_8:  keep = 5'd8;
      AGC_WL_10: keep = 5'd10;
      AGC_WL_12: keep = 5'd12;
      default:   keep = 5'd16;
    endcase
  end

  logic [23:0] mask;
  logic [23:0] c_i, c_q;
  logic [23:0] e_i, e_q;
  assign mask = ~((24'h1 << (5'd24 - keep)) - 24'h1);
  assign c_i  = g_i & mask;
  assign c_q  = g_q & mask;
  assign e_i  = g_i - c_i;
  assign e_q  = g_q - c_q;

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      out_valid_o <= 1'b0;
      out_i_o     <= 16'h0;
      out_q_o     <= 16'h0;
    end else begin
      out_valid_o <= in_valid_i;
      if (in_valid_i) begin
        if (bypass) begin
          out_i_o <= in_i_i[23:8];
          out_q_o <= in_q_i[23:8];
        end else begin
          out_i_o <= c_i[23:8];
          out_q_o <= c_q[23:8];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Power, scaling and first-order integrate-comb decimator
  // ----------------------------------------------------------------
  logic signed [23:0] m_i, m_q;
  logic [47:0]        pwr;
  logic [47:0]        pwr_s;
  logic [3:0]         scale_c;
  assign m_i     = signed'(clip_mode ? e_i : g_i);
  assign m_q     = signed'(clip_mode ? e_q : g_q);
  assign pwr     = 48'(m_i * m_i) + 48'(m_q * m_q);
  assign scale_c = (scale > `AGC_SCALE_MAX) ? `AGC_SCALE_MAX : scale;
  assign pwr_s   = pwr >> scale_c;

  // Window = M x N; comb uses a buffer of past integrator values
  logic [63:0] integ_q;
  logic [63:0] hist_q [0:3];
  logic [11:0] cnt_q;
  logic        dec_tick;
  assign dec_tick = in_valid_i && !bypass && (cnt_q == ratio_q);

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt_q   <= 12'h000;
      integ_q <= 64'h0;
    end else if (in_valid_i && !bypass) begin
      integ_q <= integ_q + 64'(pwr_s);
      cnt_q   <= dec_tick ? 12'h000 : cnt_q + 12'h001;
    end
  end

  // Ratio register holds M-1, so zero means every sample
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_hist
      if (gi == 0) begin : g_head
        always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
          if (!arst_n_i) begin
            hist_q[gi] <= 64'h0;
          end else if (dec_tick) begin
            hist_q[gi] <= integ_q + 64'(pwr_s);
          end
        end
      end else begin : g_tail
        always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
          if (!arst_n_i) begin
            hist_q[gi] <= 64'h0;
          end else if (dec_tick) begin
            hist_q[gi] <= hist_q[gi-1];
          end
        end
      end
    end
  endgenerate

  logic [63:0] avg_sum;
  logic [63:0] new_int;
  assign new_int = integ_q + 64'(pwr_s);
  assign avg_sum = new_int - hist_q[mul_code];

  // ----------------------------------------------------------------
  // Log2, rms and error
  // ----------------------------------------------------------------
  // Log word: 6-bit integer part, 6-bit fraction from linear bits
  logic [63:0] dpow_q;
  logic [11:0] log_q;
  logic [5:0]  lead;
  logic [63:0] norm;
  always_comb begin
    lead = 6'h0;
    for (int b = 0; b < 64; b++) begin
      if (dpow_q[b]) lead = 6'(b);
    end
    norm = dpow_q << (6'd63 - lead);
  end

  logic [11:0] level;
  logic [11:0] rms;
  logic [7:0]  lvl_word;
  assign lvl_word = clip_mode ? clip_level_q : target_output_level_q;
  // Exponent step 6.02 dB = one log2 unit of rms, mantissa 1/64
  assign level = {4'h0, lvl_word[7:6], lvl_word[5:0]};
  assign rms   = {1'b0, log_q[11:1]};

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_q     <= AGC_ST_IDLE;
      dpow_q      <= 64'h0;
      log_q       <= 12'h000;
      err_q       <= 12'h000;
      err_valid_o <= 1'b0;
    end else begin
      err_valid_o <= 1'b0;
      case (state_q)
        AGC_ST_IDLE: begin
          if (dec_tick) begin
            dpow_q  <= avg_sum;
            state_q <= AGC_ST_LOG;
          end
        end
        AGC_ST_LOG: begin
          log_q   <= {lead, norm[62:57]};
          state_q <= AGC_ST_ERR;
        end
        AGC_ST_ERR: begin
          // Level counts down from full scale, so negate it
          err_q       <= 12'(12'h000 - level) - (12'h600 - rms);
          err_valid_o <= 1'b1;
          state_q     <= AGC_ST_IDLE;
        end
        default: state_q <= AGC_ST_IDLE;
      endcase
    end
  end
  assign err_o = err_q;

  // Gain from the loop filter is taken once per update
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      gain_q <= `AGC_RST_GAIN;
    end else if (loop_gain_valid_i) begin
      gain_q <= loop_gain_i;
    end
  end

endmodule : agc_power_error_path

/* File: agc_power_error_path_checker.sv */
// Purpose: Port assertions for the gain error path
// Assumes: Loop gain held at unity; ratio fixed while counting
// Notes:   Mirrors control, target and ratio from the write strobe
`include "agc_map.svh"
module agc_power_error_path_checker
  import agc_pkg::*;
(
  // Clock, reset, register port
  input wire logic        ref_clk_i,
  input wire logic        arst_n_i,
  input wire logic [3:0]  reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic        reg_wr_i,
  input wire logic        reg_rd_i,
  input wire logic [31:0] reg_rdata_o,
  // Samples and loop
  input wire logic        in_valid_i,
  input wire logic [23:0] in_i_i,
  input wire logic [23:0] in_q_i,
  input wire logic        err_valid_o,
  input wire logic [11:0] err_o,
  input wire logic        loop_gain_valid_i,
  input wire logic [11:0] loop_gain_i,
  input wire logic        out_valid_o,
  input wire logic [15:0] out_i_o,
  input wire logic [15:0] out_q_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0]  ctrl_q;
  logic [7:0]  tgt_q;
  logic [11:0] ratio_q;
  logic [11:0] cnt_q;
  logic        win_end;
  logic [15:0] mask;
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!arst_n_i);
  // ----
  // Helper mirrors
  // ----
  assign win_end = in_valid_i && !ctrl_q[0] && (cnt_q == ratio_q);
  always_comb begin
    case (ctrl_q[4:2])
      3'h0: mask = 16'hF000;
      3'h1: mask = 16'hF800;
      3'h2: mask = 16'hFC00;
      3'h3: mask = 16'hFE00;
      3'h4: mask = 16'hFF00;
      3'h5: mask = 16'hFFC0;
      3'h6: mask = 16'hFFF0;
      default: mask = 16'hFFFF;
    endcase
  end
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ctrl_q  <= 8'h00;
      tgt_q   <= 8'h00;
      ratio_q <= 12'h000;
    end else if (reg_wr_i) begin
      if (reg_addr_i == `AGC_OFS_CTRL) ctrl_q <= reg_wdata_i[7:0];
      if (reg_addr_i == `AGC_OFS_TARGET) tgt_q <= reg_wdata_i[7:0];
      if (reg_addr_i == `AGC_OFS_RATIO) ratio_q <= reg_wdata_i[11:0];
    end
  end
  // Bypass freezes the window count, so no update is owed
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt_q <= 12'h000;
    end else if (in_valid_i && !ctrl_q[0]) begin
      cnt_q <= win_end ? 12'h000 : cnt_q + 12'h001;
    end
  end
  // ----
  // Assertions
  // ----
  chk_out_follows: assert property (in_valid_i |=> out_valid_o)
    else $error("sample output missing");
  chk_bypass_trunc: assert property (in_valid_i && ctrl_q[0] |=>
    out_i_o == $past(in_i_i[23:8]) && out_q_o == $past(in_q_i[23:8]))
    else $error("bypass output not truncated");
  chk_wl_trunc: assert property (in_valid_i && !ctrl_q[0] |=>
    out_i_o == ($past(in_i_i[23:8]) & $past(mask)) &&
    out_q_o == ($past(in_q_i[23:8]) & $past(mask)))
    else $error("word length output wrong");
  chk_err_timing: assert property (win_end |-> ##3 err_valid_o)
    else $error("update missing after window");
  chk_err_cause: assert property (err_valid_o |-> $past(win_end, 3))
    else $error("update without window end");
  chk_err_pulse: assert property (err_valid_o |=> !err_valid_o)
    else $error("update strobe too long");
  chk_err_held: assert property ($changed(err_o) |-> err_valid_o)
    else $error("error changed between updates");
  chk_target_read: assert property
    (reg_rd_i && reg_addr_i == `AGC_OFS_TARGET |=>
     reg_rdata_o == {24'h000000, tgt_q})
    else $error("target level readback wrong");
endmodule : agc_power_error_path_checker

bind agc_power_error_path agc_power_error_path_checker
  u_agc_power_error_path_checker (.*);

/* File: agc_power_error_path_test.sv */
// Purpose: Self-checking bench for the gain error path
// Assumes: Unity loop gain from the filter stand-in
// Notes:   Expected results queue up; a monitor pops them
module agc_power_error_path_test;
  timeunit 1ns;
  timeprecision 1ps;
  import agc_pkg::*;
  logic        ref_clk_i = 1'b0;
  logic        arst_n_i = 1'b0;
  logic [3:0]  reg_addr_i = 4'h0;
  logic [31:0] reg_wdata_i = 32'h0;
  logic        reg_wr_i = 1'b0;
  logic        reg_rd_i = 1'b0;
  logic        in_valid_i = 1'b0;
  logic [23:0] in_i_i = 24'h0;
  logic [23:0] in_q_i = 24'h0;
  logic [3:0]  lf_delay = 4'h0;
  logic        rd_pend = 1'b0;
  logic [31:0] reg_rdata_o;
  logic        err_valid_o, loop_gain_valid_i, out_valid_o;
  logic [11:0] err_o, loop_gain_i;
  logic [15:0] out_i_o, out_q_o;
  logic [31:0] rq[$];
  logic [31:0] sq[$];
  logic [31:0] v;
  logic [11:0] m;
  logic [11:0] ev;
  logic [31:0] eq[$];
  int          n_fail, checked, n_err;
  agc_power_error_path u_agc_power_error_path (.*);
  agc_loop_filter_model u_agc_loop_filter_model (.ref_clk_i, .arst_n_i,
    .err_valid_i(err_valid_o), .delay_i(lf_delay),
    .gain_valid_o(loop_gain_valid_i), .gain_o(loop_gain_i));
  always #2.5 ref_clk_i = ~ref_clk_i;
  always @(posedge ref_clk_i) rd_pend <= reg_rd_i;
  // ----
  // Tasks
  // ----
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic tally_and_finish;
    $display("checked=%0d n_fail=%0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : tally_and_finish
  task automatic bus(input logic w, input logic [3:0] a,
                     input logic [31:0] d);
    if (!w) rq.push_back(d);
    @(posedge ref_clk_i);
    reg_addr_i  <= a;
    reg_wdata_i <= w ? d : 32'($urandom);
    reg_wr_i    <= w;
    reg_rd_i    <= !w;
    @(posedge ref_clk_i);
    reg_wr_i    <= 1'b0;
    reg_rd_i    <= 1'b0;
  endtask : bus
  task automatic samp(input logic byp, input logic [2:0] wl,
                      input logic [23:0] fix);
    logic [23:0] i;
    logic [23:0] q;
    logic [15:0] k;
    i = (fix != 24'h0) ? fix : 24'($urandom);
    q = (fix != 24'h0) ? fix : 24'($urandom);
    k = byp ? 16'hFFFF : 16'hFFFF << (wl < 3'h5 ? 12 - wl : 12 - 2 * wl + 4);
    if (wl == 3'h7) k = 16'hFFFF;
    sq.push_back({i[23:8] & k, q[23:8] & k});
    @(posedge ref_clk_i);
    in_valid_i <= 1'b1;
    in_i_i     <= i;
    in_q_i     <= q;
    @(posedge ref_clk_i);
    in_valid_i <= 1'b0;
    in_i_i     <= ~i;
    in_q_i     <= ~q;
  endtask : samp
  // ----
  // Monitor
  // ----
  always @(negedge ref_clk_i) begin
    if (out_valid_o === 1'b1)
      check({out_i_o, out_q_o}, sq.size() ? sq.pop_front() : 'x);
    if (rd_pend) check(reg_rdata_o, rq.size() ? rq.pop_front() : 'x);
    if (err_valid_o === 1'b1 && eq.size() > 0)
      check({20'h0, err_o}, eq.pop_front());
    if (err_valid_o === 1'b1) n_err++;
  end
  initial begin
    #20000;
    n_fail++;
    tally_and_finish();
  end
  // ----
  // Scenarios
  // ----
  initial begin
    void'($urandom(23501));
    repeat (12) @(posedge ref_clk_i);
    arst_n_i <= 1'b1;
    repeat (2) @(posedge ref_clk_i);
    for (int a = 0; a < 16; a++) bus(0, a, a == 7 ? 32'h1 : 32'h0);
    for (int a = 0; a < 7; a++) begin
      v = 32'($urandom) & (a == 2 ? 32'hFFF : a == 3 ? 32'hE3 : 32'hFF);
      if (a == 0) v = v & 32'h1F;
      bus(1, a, v);
      bus(0, a, a > 4 ? 32'h0 : v);
    end
    bus(1, 4'h9, 32'($urandom));
    bus(0, 4'h9, 32'h0);
    m = 12'($urandom_range(7));
    bus(1, 4'h2, {20'h0, m});
    bus(1, 4'h0, 32'h1);
    repeat (6) samp(1, 3'h0, 24'h0);
    check(n_err, 0);
    for (int w = 0; w < 8; w++) begin
      lf_delay <= w[0] ? 4'h9 : 4'h0;
      bus(1, 4'h0, {27'h0, w[2:0], w[0], 1'b0});
      repeat (m + 1) samp(0, w[2:0], 24'h0);
    end
    repeat (20) @(posedge ref_clk_i);
    check(n_err, 8);
    bus(1, 4'h0, 32'h1);
    repeat (m + 1) samp(1, 3'h0, 24'h0);
    bus(0, 4'h5, 32'h0);
    check(n_err, 8);
    // Known power: four equal samples make an exact power of two
    v = 32'($urandom) & 32'hFF;
    bus(1, 4'h1, v);
    bus(1, 4'h3, 32'h20);
    bus(1, 4'h2, 32'h3);
    bus(1, 4'h0, 32'h0);
    ev = 12'(12'h000 - {4'h0, v[7:0]} - 12'h360);
    eq.push_back({20'h0, ev});
    repeat (4) samp(0, 3'h0, 24'h000400);
    repeat (6) @(posedge ref_clk_i);
    bus(0, 4'h6, {20'h0, ev});
    // Clip mode: only the bits cut below the 16-bit word count
    v = 32'($urandom) & 32'hFF;
    bus(1, 4'h4, v);
    bus(1, 4'h3, 32'h0);
    bus(1, 4'h0, 32'h1E);
    ev = 12'(12'h000 - {4'h0, v[7:0]} - 12'h420);
    eq.push_back({20'h0, ev});
    repeat (4) samp(0, 3'h7, 24'h000040);
    repeat (6) @(posedge ref_clk_i);
    bus(0, 4'h6, {20'h0, ev});
    check(n_err, 10);
    check(eq.size(), 0);
    tally_and_finish();
  end
endmodule : agc_power_error_path_test
